// ==== shared/rx_event_defines.vh ====
`ifndef RX_EVENT_DEFINES_VH
`define RX_EVENT_DEFINES_VH
// byte offsets on the register bus
`define OFS_ELASTIC_TIMER 12'h24c
`define OFS_HDLC_RX 12'h250
`define OFS_LINK_SPARE 12'h258
`define OFS_SIG_CHG_1_8 12'h260
`define OFS_SIG_CHG_9_16 12'h264
`define OFS_SIG_CHG_17_24 12'h268
`define OFS_SIG_CHG_25_32 12'h26c
`define OFS_ELASTIC_TIMER_MASK 12'h300
`define OFS_HDLC_MASK 12'h304
`define OFS_LINK_SPARE_MASK 12'h308
`define OFS_CONFIG 12'h30c
`define OFS_SIG_ENABLE 12'h310
`define OFS_SPARE_MASK 12'h314
// elastic/timer register fields
`define BIT_STORE_FULL 7
`define BIT_STORE_EMPTY 6
`define BIT_SLIP 5
`define BIT_SIG_CHANGE 3
`define BIT_ONE_SECOND 2
`define BIT_COUNTER_UPDATE 1
`define BIT_MULTIFRAME 0
// config register fields
`define CFG_E1_MODE 0
`define CFG_ESF 1
`define CFG_SHORT_UPDATE 2
`define CFG_MANUAL_LATCH 3
// reserved bit masks
`define MASK_ELASTIC 8'hef
`define MASK_HDLC 8'h3f
`define MASK_T1_LINK 8'h3f
`define MASK_E1_SPARE 8'h03
// timing in microseconds, clock frequency in MHz
`define T_ONE_SECOND_US 1000000
`define T_T1_UPDATE_US 42000
`define T_E1_UPDATE_US 62500
`define T_SF_MF_US 1500
`define T_ESF_MF_US 3000
`define T_E1_MF_US 2000
`define CLK_MHZ 200
`endif

// ==== verilog/interval_timer.v ====
`include "rx_event_defines.vh"
// free-running interval counter, one-cycle tick at terminal count
module interval_timer #(
	parameter WIDTH = 28
) (
	// clock and reset
	input wire i_clk,
	input wire i_rstn,
	// control
	input wire [WIDTH-1:0] i_period,
	input wire i_restart,
	// tick
	output reg o_tick
);
	reg [WIDTH-1:0] count;

	// counts period cycles then ticks
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			count <= {WIDTH{1'b0}};
			o_tick <= 1'b0;
		end else if (i_restart) begin
			count <= {WIDTH{1'b0}};
			o_tick <= 1'b0;
		end else if (count >= i_period - {{(WIDTH-1){1'b0}}, 1'b1}) begin
			count <= {WIDTH{1'b0}};
			o_tick <= 1'b1;
		end else begin
			count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
			o_tick <= 1'b0;
		end
	end
endmodule // interval_timer

// ==== verilog/rx_framer_event_latches.v ====
// Functional notes
// - slip latch sets whenever store-full or store-empty event occurs
// - latched bits stay set until software writes one there; switching to E1 mode clears link bits 5:2
// - set bit requests interrupt only when its mask bit is one
// - signalling change latch sets on change of an enabled channel
// - one-second latch sets every second counted in receive clocks
// - T1 counter-update latch every 1 s or 42 ms, or manual
// - E1 counter-update latch every 1 s or 62.5 ms, or manual
// - T1 multiframe latch: 1.5 ms SF, 3 ms ESF boundaries
// - E1 multiframe latch every 2 ms, also without CAS
// - overrun latch sets when HDLC packet abandoned on full FIFO
// - opening-byte latch sets when next FIFO byte starts a message
// - packet-end latch sets on good end or faulted end of message
// - packet-start latch sets when opening byte is detected
// - high-watermark latch sets on rising above-watermark status
// - not-empty latch sets on rising FIFO-holds-data status
// - T1 remote-alarm CI latch: ESF only, remote alarm active
// - T1 alarm-signal CI latch only while alarm signal active
// - T1 SLC-96 latch sets on valid alignment with new data
// - T1 datalink-full latch sets when receive data register fills
// - T1 code detect and code clear latches from the code filters
// - E1 Sa6 codeword latch sets on valid codeword
// - E1 spare-bit change latch sets on change of an unmasked Sa bit
// - store-full and store-empty latches set on delete and repeat
// - per-channel signalling change latch for channels 1 to 32
`include "rx_event_defines.vh"
module rx_framer_event_latches #(
	parameter SEC_CYCLES = `T_ONE_SECOND_US * `CLK_MHZ,
	parameter T1_UPD_CYCLES = `T_T1_UPDATE_US * `CLK_MHZ,
	parameter E1_UPD_CYCLES = `T_E1_UPDATE_US * `CLK_MHZ,
	parameter SF_MF_CYCLES = `T_SF_MF_US * `CLK_MHZ,
	parameter ESF_MF_CYCLES = `T_ESF_MF_US * `CLK_MHZ,
	parameter E1_MF_CYCLES = `T_E1_MF_US * `CLK_MHZ
) (
	// clock and reset
	input wire i_clk,
	input wire i_rstn,
	// ahb-lite slave
	input wire i_hsel,
	input wire [31:0] i_haddr,
	input wire [1:0] i_htrans,
	input wire i_hwrite,
	input wire [2:0] i_hsize,
	input wire [31:0] i_hwdata,
	input wire i_hready,
	output reg [31:0] o_hrdata,
	output reg o_hreadyout,
	output reg o_hresp,
	// elastic store and signalling events (pulses, same clock)
	input wire i_store_full_event,
	input wire i_store_empty_event,
	input wire [31:0] i_chan_sig_change,
	// hdlc receiver events and status
	input wire i_hdlc_overrun_event,
	input wire i_opening_byte_event,
	input wire i_packet_end_event,
	input wire i_packet_start_event,
	input wire i_above_high_watermark,
	input wire i_fifo_holds_data,
	// t1 alarm and link detectors
	input wire i_remote_alarm_ci_seen,
	input wire i_remote_alarm_active,
	input wire i_alarm_signal_ci_seen,
	input wire i_alarm_signal_active,
	input wire i_slc_alignment_seen,
	input wire i_datalink_full,
	input wire i_code_valid,
	// e1 spare bit detectors
	input wire i_spare6_codeword_seen,
	input wire [4:0] i_spare_bit_change,
	// received multiframe boundary (pulse)
	input wire i_mf_boundary,
	input wire i_cas_enabled,
	// interrupt requests per register
	output reg o_irq_elastic_timer,
	output reg o_irq_hdlc,
	output reg o_irq_link_spare
);
	localparam [27:0] SEC_P = SEC_CYCLES[27:0];
	localparam [27:0] T1U_P = T1_UPD_CYCLES[27:0];
	localparam [27:0] E1U_P = E1_UPD_CYCLES[27:0];
	localparam [27:0] SF_P = SF_MF_CYCLES[27:0];
	localparam [27:0] ESF_P = ESF_MF_CYCLES[27:0];
	localparam [27:0] E1M_P = E1_MF_CYCLES[27:0];

	reg [7:0] elastic_timer;
	reg [7:0] hdlc_rx;
	reg [7:0] link_spare;
	reg [31:0] sig_chg;
	reg [7:0] elastic_timer_mask;
	reg [7:0] hdlc_mask;
	reg [7:0] link_spare_mask;
	reg [7:0] ctrl;
	reg [31:0] sig_enable;
	reg [4:0] spare_mask;
	reg manual_pend;
	reg hwm_d;
	reg nonempty_d;
	reg code_valid_d;
	reg dphase_wr;
	reg [11:0] dphase_addr;
	reg [31:0] next_rdata;
	reg [7:0] next_elastic;
	reg [7:0] next_hdlc;
	reg [7:0] next_link;

	wire e1_mode = ctrl[`CFG_E1_MODE];
	wire esf = ctrl[`CFG_ESF];
	wire mode_change;
	reg e1_mode_d;
	reg esf_d;
	reg short_d;
	wire sec_tick;
	wire upd_tick;
	wire mf_tick;
	wire [27:0] upd_period;
	wire [27:0] mf_period;
	wire addr_phase = i_hsel & i_htrans[1] & i_hready;
	wire [31:0] wr_data = i_hwdata;

	// restart update and multiframe timers when framing mode settings change
	assign mode_change = (e1_mode != e1_mode_d) | (esf != esf_d) |
		(ctrl[`CFG_SHORT_UPDATE] != short_d);
	assign upd_period = ctrl[`CFG_SHORT_UPDATE] ?
		(e1_mode ? E1U_P : T1U_P) : SEC_P;
	assign mf_period = e1_mode ? E1M_P : (esf ? ESF_P : SF_P);

	// one-second tick
	interval_timer #(.WIDTH(28)) u_sec (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_period(SEC_P),
		.i_restart(1'b0),
		.o_tick(sec_tick)
	);

	// counter-update tick
	interval_timer #(.WIDTH(28)) u_upd (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_period(upd_period),
		.i_restart(mode_change),
		.o_tick(upd_tick)
	);

	// free-running multiframe tick when no boundary is supplied
	interval_timer #(.WIDTH(28)) u_mf (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_period(mf_period),
		.i_restart(mode_change | i_mf_boundary),
		.o_tick(mf_tick)
	);

	// write-one-to-clear mask for the addressed register
	function [7:0] w1c;
		input [11:0] a;
		input [11:0] ofs;
		input wr;
		input [7:0] d;
		begin
			w1c = (wr && a == ofs) ? d : 8'h00;
		end
	endfunction

	// next latch values: set wins over clear
	always @* begin
		next_elastic = elastic_timer & ~w1c(dphase_addr,
			`OFS_ELASTIC_TIMER, dphase_wr, wr_data[7:0]);
		next_elastic[`BIT_STORE_FULL] = next_elastic[`BIT_STORE_FULL] |
			i_store_full_event;
		next_elastic[`BIT_STORE_EMPTY] = next_elastic[`BIT_STORE_EMPTY] |
			i_store_empty_event;
		next_elastic[`BIT_SLIP] = next_elastic[`BIT_SLIP] |
			i_store_full_event | i_store_empty_event;
		next_elastic[`BIT_SIG_CHANGE] = next_elastic[`BIT_SIG_CHANGE] |
			(|(i_chan_sig_change & sig_enable));
		next_elastic[`BIT_ONE_SECOND] = next_elastic[`BIT_ONE_SECOND] |
			sec_tick;
		next_elastic[`BIT_COUNTER_UPDATE] =
			next_elastic[`BIT_COUNTER_UPDATE] | upd_tick |
			manual_pend;
		next_elastic[`BIT_MULTIFRAME] = next_elastic[`BIT_MULTIFRAME] |
			(i_cas_enabled | ~e1_mode ? i_mf_boundary : mf_tick) |
			(~i_cas_enabled & e1_mode & i_mf_boundary);
		next_elastic = next_elastic & `MASK_ELASTIC;

		next_hdlc = hdlc_rx & ~w1c(dphase_addr, `OFS_HDLC_RX,
			dphase_wr, wr_data[7:0]);
		next_hdlc[5] = next_hdlc[5] | i_hdlc_overrun_event;
		next_hdlc[4] = next_hdlc[4] | i_opening_byte_event;
		next_hdlc[3] = next_hdlc[3] | i_packet_end_event;
		next_hdlc[2] = next_hdlc[2] | i_packet_start_event;
		next_hdlc[1] = next_hdlc[1] |
			(i_above_high_watermark & ~hwm_d);
		next_hdlc[0] = next_hdlc[0] |
			(i_fifo_holds_data & ~nonempty_d);
		next_hdlc = next_hdlc & `MASK_HDLC;

		next_link = link_spare & ~w1c(dphase_addr, `OFS_LINK_SPARE,
			dphase_wr, wr_data[7:0]);
		if (e1_mode) begin
			next_link[1] = next_link[1] | i_spare6_codeword_seen;
			next_link[0] = next_link[0] |
				(|(i_spare_bit_change & ~spare_mask));
			next_link = next_link & `MASK_E1_SPARE;
		end else begin
			next_link[5] = next_link[5] | (i_remote_alarm_ci_seen & esf &
				i_remote_alarm_active);
			next_link[4] = next_link[4] | (i_alarm_signal_ci_seen &
				i_alarm_signal_active);
			next_link[3] = next_link[3] | i_slc_alignment_seen;
			next_link[2] = next_link[2] | i_datalink_full;
			next_link[1] = next_link[1] |
				(~i_code_valid & code_valid_d);
			next_link[0] = next_link[0] |
				(i_code_valid & ~code_valid_d);
			next_link = next_link & `MASK_T1_LINK;
		end
	end

	// read data mux
	always @* begin
		case (i_haddr[11:0])
			`OFS_ELASTIC_TIMER: next_rdata = {24'h000000, elastic_timer};
			`OFS_HDLC_RX: next_rdata = {24'h000000, hdlc_rx};
			`OFS_LINK_SPARE: next_rdata = {24'h000000, link_spare};
			`OFS_SIG_CHG_1_8: next_rdata = {24'h000000, sig_chg[7:0]};
			`OFS_SIG_CHG_9_16: next_rdata = {24'h000000, sig_chg[15:8]};
			`OFS_SIG_CHG_17_24: next_rdata = {24'h000000, sig_chg[23:16]};
			`OFS_SIG_CHG_25_32: next_rdata = {24'h000000, sig_chg[31:24]};
			`OFS_ELASTIC_TIMER_MASK:
				next_rdata = {24'h000000, elastic_timer_mask};
			`OFS_HDLC_MASK: next_rdata = {24'h000000, hdlc_mask};
			`OFS_LINK_SPARE_MASK: next_rdata = {24'h000000, link_spare_mask};
			`OFS_CONFIG: next_rdata = {24'h000000, ctrl};
			`OFS_SIG_ENABLE: next_rdata = sig_enable;
			`OFS_SPARE_MASK: next_rdata = {27'h0, spare_mask};
			default: next_rdata = 32'h00000000;
		endcase
	end

	// per-channel signalling change latches
	genvar ch;
	generate
		for (ch = 0; ch < 32; ch = ch + 1) begin : g_chan
			wire clr_hit = dphase_wr &&
				dphase_addr == `OFS_SIG_CHG_1_8 + ch / 8 * 4 &&
				wr_data[ch % 8];
			always @(posedge i_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					sig_chg[ch] <= 1'b0;
				end else begin
					sig_chg[ch] <= i_chan_sig_change[ch] |
						(sig_chg[ch] & ~clr_hit);
				end
			end
		end
	endgenerate

	// bus slave, latches and control registers
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_hrdata <= 32'h00000000;
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
			dphase_wr <= 1'b0;
			dphase_addr <= 12'h000;
			elastic_timer <= 8'h00;
			hdlc_rx <= 8'h00;
			link_spare <= 8'h00;
			elastic_timer_mask <= 8'h00;
			hdlc_mask <= 8'h00;
			link_spare_mask <= 8'h00;
			ctrl <= 8'h00;
			sig_enable <= 32'h00000000;
			spare_mask <= 5'h1f;
			manual_pend <= 1'b0;
		end else begin
			dphase_wr <= addr_phase & i_hwrite;
			dphase_addr <= i_haddr[11:0];
			if (addr_phase & ~i_hwrite) begin
				o_hrdata <= next_rdata;
			end
			elastic_timer <= next_elastic;
			hdlc_rx <= next_hdlc;
			link_spare <= next_link;
			manual_pend <= 1'b0;
			if (dphase_wr) begin
				case (dphase_addr)
					`OFS_ELASTIC_TIMER_MASK:
						elastic_timer_mask <= wr_data[7:0] & `MASK_ELASTIC;
					`OFS_HDLC_MASK: hdlc_mask <= wr_data[7:0] & `MASK_HDLC;
					`OFS_LINK_SPARE_MASK:
						link_spare_mask <= wr_data[7:0] & `MASK_T1_LINK;
					`OFS_CONFIG: begin
						ctrl <= {5'h00, wr_data[2:0]};
						manual_pend <= wr_data[`CFG_MANUAL_LATCH];
					end
					`OFS_SIG_ENABLE: sig_enable <= wr_data;
					`OFS_SPARE_MASK: spare_mask <= wr_data[4:0];
					default: manual_pend <= 1'b0;
				endcase
			end
		end
	end

	// level history for edge-detected status, idle low after reset
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			hwm_d <= 1'b0;
			nonempty_d <= 1'b0;
			code_valid_d <= 1'b0;
		end else begin
			hwm_d <= i_above_high_watermark;
			nonempty_d <= i_fifo_holds_data;
			code_valid_d <= i_code_valid;
		end
	end

	// mode history, any change restarts the update and multiframe timers
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			e1_mode_d <= 1'b0;
			esf_d <= 1'b0;
			short_d <= 1'b0;
		end else begin
			e1_mode_d <= e1_mode;
			esf_d <= esf;
			short_d <= ctrl[`CFG_SHORT_UPDATE];
		end
	end

	// interrupt requests, one cycle behind latches and masks
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_irq_elastic_timer <= 1'b0;
			o_irq_hdlc <= 1'b0;
			o_irq_link_spare <= 1'b0;
		end else begin
			o_irq_elastic_timer <= |(elastic_timer &
				elastic_timer_mask);
			o_irq_hdlc <= |(hdlc_rx &
				hdlc_mask);
			o_irq_link_spare <= |(link_spare &
				link_spare_mask);
		end
	end
endmodule // rx_framer_event_latches

// ==== verification/rx_event_latches_chk.sv ====
module rx_event_latches_chk (
	// clock and reset
	input wire i_clk,
	input wire i_rstn,
	// bus
	input wire i_hsel,
	input wire [1:0] i_htrans,
	input wire i_hwrite,
	input wire i_hready,
	input wire o_hreadyout,
	input wire o_hresp,
	// hdlc causes
	input wire i_hdlc_overrun_event,
	input wire i_opening_byte_event,
	input wire i_packet_end_event,
	input wire i_packet_start_event,
	input wire i_above_high_watermark,
	input wire i_fifo_holds_data,
	// requests
	input wire o_irq_elastic_timer,
	input wire o_irq_hdlc,
	input wire o_irq_link_spare
);
	logic wr_dp;
	logic hwm_q;
	logic dat_q;
	wire hev;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);
	// write data phase marker and level history
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			{wr_dp, hwm_q, dat_q} <= 3'h0;
		end else begin
			{wr_dp, hwm_q, dat_q} <= {i_hsel & i_htrans[1] & i_hready & i_hwrite,
				i_above_high_watermark, i_fifo_holds_data};
		end
	end
	// any cause that may set an hdlc latch
	assign hev = i_hdlc_overrun_event | i_opening_byte_event |
		i_packet_end_event | i_packet_start_event |
		(i_above_high_watermark & ~hwm_q) | (i_fifo_holds_data & ~dat_q);
	chk_ready_high: assert property (o_hreadyout)
		else $error("hreadyout low");
	chk_resp_okay: assert property (!o_hresp)
		else $error("error response");
	chk_reset_quiet: assert property ($rose(i_rstn) |->
		!(o_irq_hdlc | o_irq_link_spare | o_irq_elastic_timer))
		else $error("request right after reset");
	chk_hdlc_fall: assert property ($fell(o_irq_hdlc) |->
		$past(wr_dp, 2))
		else $error("hdlc request dropped without a write");
	chk_link_fall: assert property ($fell(o_irq_link_spare) |->
		$past(wr_dp, 2))
		else $error("link request dropped without a write");
	chk_elastic_fall: assert property ($fell(o_irq_elastic_timer) |->
		$past(wr_dp, 2))
		else $error("elastic request dropped without a write");
	chk_hdlc_rise: assert property ($rose(o_irq_hdlc) |->
		$past(hev | wr_dp, 2))
		else $error("hdlc request without cause");
	chk_hdlc_hold: assert property (!(hev | wr_dp) ##2 1'b1 |->
		$stable(o_irq_hdlc))
		else $error("hdlc request moved without cause");
endmodule // rx_event_latches_chk

// ==== verification/tb.sv ====
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk, i_rstn, hsel, hwrite;
	logic [31:0] haddr, hwdata, chg, rd;
	logic [1:0] htrans;
	logic [17:0] ev;
	logic [4:0] sa;
	logic [2:0] hsize;
	wire [31:0] hrdata;
	wire hrdy, hresp, irq_e, irq_h, irq_l;
	int miscompares, cmp_count;
	// shortened intervals, in clock cycles
	localparam int SEC_T = 200;
	localparam int T1U_T = 60;
	localparam int E1U_T = 80;
	localparam int SF_T = 40;
	localparam int ESF_T = 70;
	localparam int E1M_T = 50;
	// device with shortened intervals
	rx_framer_event_latches #(.SEC_CYCLES(SEC_T), .T1_UPD_CYCLES(T1U_T),
		.E1_UPD_CYCLES(E1U_T), .SF_MF_CYCLES(SF_T),
		.ESF_MF_CYCLES(ESF_T),
		.E1_MF_CYCLES(E1M_T)) rx_framer_event_latches_i (
		.i_clk(i_clk), .i_rstn(i_rstn), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
		.i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
		.o_hreadyout(hrdy), .o_hresp(hresp),
		.i_store_full_event(ev[0]), .i_store_empty_event(ev[1]),
		.i_chan_sig_change(chg), .i_hdlc_overrun_event(ev[2]),
		.i_opening_byte_event(ev[3]), .i_packet_end_event(ev[4]),
		.i_packet_start_event(ev[5]), .i_above_high_watermark(ev[6]),
		.i_fifo_holds_data(ev[7]), .i_remote_alarm_ci_seen(ev[8]),
		.i_remote_alarm_active(ev[9]), .i_alarm_signal_ci_seen(ev[10]),
		.i_alarm_signal_active(ev[11]), .i_slc_alignment_seen(ev[12]),
		.i_datalink_full(ev[13]), .i_code_valid(ev[14]),
		.i_spare6_codeword_seen(ev[15]), .i_spare_bit_change(sa),
		.i_mf_boundary(ev[16]), .i_cas_enabled(ev[17]),
		.o_irq_elastic_timer(irq_e), .o_irq_hdlc(irq_h),
		.o_irq_link_spare(irq_l));
	// clock
	initial begin
		i_clk = 0;
		forever #2.5 i_clk = ~i_clk;
	end
	task give_verdict;
		if (miscompares == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input [31:0] g, input [31:0] e);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	// wait for hready, bounded
	task rdy;
		int n;
		n = 0;
		@(posedge i_clk);
		while (hrdy !== 1'b1) begin
			n++;
			if (n > 50) begin
				miscompares++;
				give_verdict;
			end
			@(posedge i_clk);
		end
	endtask
	// one single word transfer
	task acc(input w, input [11:0] a, input [31:0] d);
		@(posedge i_clk);
		hsel <= 1;
		haddr <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		rdy;
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
		rd = hrdata;
	endtask
	task rc(input [11:0] a, input [31:0] m, input [31:0] e);
		acc(0, a, 0);
		chk(rd & m, e);
	endtask
	task pulse(input int b);
		@(posedge i_clk);
		ev[b] <= 1;
		@(posedge i_clk);
		ev[b] <= 0;
	endtask
	task lvl(input int b, input v);
		@(posedge i_clk);
		ev[b] <= v;
	endtask
	task t_reset;
		rc(12'h24c, 32'hfffffff8, 0);
		rc(12'h250, 32'hffffffff, 0);
		rc(12'h258, 32'hffffffff, 0);
		for (int i = 0; i < 4; i++) rc(12'h260 + 12'(i * 4), 32'hff, 0);
		rc(12'h400, 32'hffffffff, 0);
	endtask
	task t_hdlc;
		acc(1, 12'h304, 32'h3f);
		for (int b = 2; b < 6; b++) pulse(b);
		lvl(6, 1);
		lvl(7, 1);
		rc(12'h250, 32'hffffffff, 32'h3f);
		chk(irq_h, 1);
		acc(1, 12'h250, 0);
		rc(12'h250, 32'hffffffff, 32'h3f);
		acc(1, 12'h250, 32'h05);
		rc(12'h250, 32'hffffffff, 32'h3a);
		acc(1, 12'h304, 0);
		repeat (2) @(posedge i_clk);
		chk(irq_h, 0);
		acc(1, 12'h304, 32'h3f);
		repeat (2) @(posedge i_clk);
		chk(irq_h, 1);
		acc(1, 12'h250, 32'hff);
		rc(12'h250, 32'hffffffff, 0);
		chk(irq_h, 0);
		lvl(6, 0);
		lvl(7, 0);
	endtask
	task t_elastic;
		acc(1, 12'h300, 32'he8);
		acc(1, 12'h24c, 32'hff);
		pulse(0);
		rc(12'h24c, 32'hf8, 32'ha0);
		chk(irq_e, 1);
		acc(1, 12'h24c, 32'he0);
		pulse(1);
		rc(12'h24c, 32'hf8, 32'h60);
		acc(1, 12'h24c, 32'hff);
		acc(1, 12'h310, 32'h1);
		@(posedge i_clk) chg <= 32'h3;
		@(posedge i_clk) chg <= 0;
		rc(12'h24c, 32'hf8, 32'h08);
		rc(12'h260, 32'hff, 32'h03);
		acc(1, 12'h24c, 32'hff);
		acc(1, 12'h260, 32'hff);
		@(posedge i_clk) chg <= 32'h2;
		@(posedge i_clk) chg <= 0;
		rc(12'h24c, 32'hf8, 0);
		rc(12'h260, 32'hff, 32'h02);
		chk(irq_e, 0);
		rc(12'h24c, 32'h1, 0);
		pulse(16);
		rc(12'h24c, 32'h1, 1);
	endtask
	task t_timers;
		acc(1, 12'h24c, 32'hff);
		repeat (SEC_T + 5) @(posedge i_clk);
		rc(12'h24c, 32'h4, 32'h4);
		acc(1, 12'h30c, 32'h4);
		acc(1, 12'h24c, 32'hff);
		repeat (T1U_T + 5) @(posedge i_clk);
		rc(12'h24c, 32'h2, 32'h2);
		acc(1, 12'h30c, 0);
		acc(1, 12'h24c, 32'hff);
		acc(1, 12'h30c, 32'h8);
		rc(12'h24c, 32'h2, 32'h2);
		acc(1, 12'h30c, 32'h5);
		acc(1, 12'h24c, 32'hff);
		repeat (E1U_T + 5) @(posedge i_clk);
		rc(12'h24c, 32'h2, 32'h2);
		acc(1, 12'h24c, 32'hff);
		repeat (E1M_T + 5) @(posedge i_clk);
		rc(12'h24c, 32'h1, 32'h1);
		// with cas on only received boundaries set the latch
		lvl(17, 1);
		acc(1, 12'h24c, 32'hff);
		repeat (E1M_T + 5) @(posedge i_clk);
		rc(12'h24c, 32'h1, 0);
		pulse(16);
		rc(12'h24c, 32'h1, 32'h1);
		lvl(17, 0);
	endtask
	task t_link;
		acc(1, 12'h30c, 32'h2);
		acc(1, 12'h308, 32'h3f);
		acc(1, 12'h258, 32'hff);
		lvl(9, 1);
		pulse(8);
		pulse(10);
		pulse(12);
		pulse(13);
		lvl(14, 1);
		rc(12'h258, 32'hff, 32'h2d);
		lvl(14, 0);
		rc(12'h258, 32'hff, 32'h2f);
		chk(irq_l, 1);
		acc(1, 12'h258, 32'hff);
		lvl(9, 0);
		lvl(11, 1);
		pulse(8);
		pulse(10);
		rc(12'h258, 32'hff, 32'h10);
		acc(1, 12'h30c, 0);
		acc(1, 12'h258, 32'hff);
		lvl(9, 1);
		pulse(8);
		rc(12'h258, 32'hff, 0);
		acc(1, 12'h30c, 32'h1);
		acc(1, 12'h258, 32'hff);
		acc(1, 12'h314, 32'h1e);
		@(posedge i_clk) sa <= 5'h3;
		@(posedge i_clk) sa <= 0;
		pulse(15);
		rc(12'h258, 32'hff, 32'h3);
		acc(1, 12'h258, 32'hff);
		acc(1, 12'h314, 32'h1f);
		@(posedge i_clk) sa <= 5'h1;
		@(posedge i_clk) sa <= 0;
		rc(12'h258, 32'hff, 0);
	endtask
	// reset in mid-run with a request pending
	task t_rst2;
		acc(1, 12'h304, 32'h3f);
		pulse(2);
		repeat (2) @(posedge i_clk);
		chk(irq_h, 1);
		@(posedge i_clk);
		i_rstn <= 0;
		repeat (3) @(posedge i_clk);
		i_rstn <= 1;
		chk(irq_h, 0);
		t_reset;
		rc(12'h304, 32'hff, 0);
	endtask
	// main sequence
	initial begin
		i_rstn = 0;
		{hsel, hwrite, htrans, haddr, hwdata, hsize} = 0;
		{ev, chg, sa} = 0;
		miscompares = 0;
		cmp_count = 0;
		repeat (6) @(posedge i_clk);
		i_rstn <= 1;
		t_reset;
		t_hdlc;
		t_elastic;
		t_timers;
		t_link;
		t_rst2;
		give_verdict;
	end
endmodule // tb
bind rx_framer_event_latches rx_event_latches_chk rx_event_latches_chk_i (
	.i_clk(i_clk), .i_rstn(i_rstn), .i_hsel(i_hsel), .i_htrans(i_htrans),
	.i_hwrite(i_hwrite), .i_hready(i_hready), .o_hreadyout(o_hreadyout),
	.o_hresp(o_hresp), .i_hdlc_overrun_event(i_hdlc_overrun_event),
	.i_opening_byte_event(i_opening_byte_event),
	.i_packet_end_event(i_packet_end_event),
	.i_packet_start_event(i_packet_start_event),
	.i_above_high_watermark(i_above_high_watermark),
	.i_fifo_holds_data(i_fifo_holds_data),
	.o_irq_elastic_timer(o_irq_elastic_timer), .o_irq_hdlc(o_irq_hdlc),
	.o_irq_link_spare(o_irq_link_spare));
